// file: drive_stop_halt_control.sv
// Quick stop, halt interruption and fast position capture control of the drive.
`timescale 1ns/1ps

// Overview of operation
// - Quick stop from software or error brakes with the quick-stop ramp.
// - After a lower-class error quick stop the power stage stays enabled.
// - After a class 2 error quick stop the power stage turns off at standstill.
// - Overvoltage while braking disables the power stage and reports the error.
// - Quick stop holds until fault reset; the controller must issue it.
// - Quick-stop ramp is 32 bits, 200 to 3000000, reset value 6000.
// - Halt at standstill adjusts position, then holds with power stage enabled.
// - Interrupted movement resumes only when every halt request is gone.
// - Halt withdrawn mid-deceleration finishes deceleration, then accelerates again.
// - Halt requests come from the software channel or a signal input.
// - Halt braking uses the profile ramp, 200 to 3000000, reset value 750.
// - Capture latches motor position when either capture input turns active.
// - End of movement is reported only once the target is reached.
module drive_stop_halt_control #(
  parameter int TICK_CYCLES = stop_ctrl_pkg::RAMP_TICK_CYCLES,
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Parameter access
  input wire logic [15:0] param_addr_i,
  input wire logic [31:0] param_wdata_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  output logic [31:0] param_rdata_o,
  output logic param_reject_o,
  // Movement and stop requests
  input wire logic [31:0] move_speed_i,
  input wire logic [31:0] accel_i,
  input wire logic power_req_i,
  input wire logic quick_stop_req_i,
  input wire logic error_low_i,
  input wire logic error_class2_i,
  input wire logic fault_reset_i,
  input wire logic halt_sw_i,
  // Pins
  input wire logic halt_pin_i,
  input wire logic dc_overvolt_pin_i,
  input wire logic [1:0] capture_pin_i,
  input wire logic [POS_W-1:0] motor_pos_i,
  // Drive status and commands
  output logic [31:0] speed_ref_o,
  output logic power_stage_en_o,
  output logic quick_stop_active_o,
  output logic halt_active_o,
  output logic pos_adjust_o,
  output logic pos_hold_o,
  output logic overvolt_err_o,
  output logic move_end_o,
  // Capture results
  output logic [POS_W-1:0] capture0_pos_o,
  output logic [POS_W-1:0] capture1_pos_o,
  output logic [1:0] capture_valid_o
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  stop_ctrl_pkg::stop_state_t state_reg;
  stop_ctrl_pkg::stop_state_t state_next;
  logic [31:0] profile_decel_ramp_reg;
  logic [31:0] quick_stop_decel_ramp_reg;
  logic [31:0] rdata_reg;
  logic reject_reg;
  logic class2_reg;
  logic overvolt_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [3:0] pin_level;
  logic halt_any;
  logic qs_trigger;
  logic overvolt;
  logic [31:0] ramp_target;
  logic [31:0] ramp_decel;
  logic [31:0] speed;
  logic at_target;
  logic braking;
  logic [1:0] cap_prev_reg;
  logic [1:0] cap_valid_reg;
  logic [POS_W-1:0] cap0_reg;
  logic [POS_W-1:0] cap1_reg;

  function automatic logic in_range(input logic [31:0] value);
    in_range = (value >= stop_ctrl_pkg::RAMP_MIN) && (value <= stop_ctrl_pkg::RAMP_MAX);
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  pin_filter #(
    .WIDTH(4)
  ) u_pin_filter (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .pin_i({capture_pin_i, dc_overvolt_pin_i, halt_pin_i}),
    .level_o(pin_level)
  );

  assign halt_any = halt_sw_i | pin_level[0];
  assign overvolt = pin_level[1];
  assign qs_trigger = quick_stop_req_i | error_low_i | error_class2_i;

  // ---------------------------------------------------------------------------
  // Parameter registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      profile_decel_ramp_reg <= stop_ctrl_pkg::PROFILE_DECEL_RESET;
      quick_stop_decel_ramp_reg <= stop_ctrl_pkg::QUICK_STOP_DECEL_RESET;
      reject_reg <= 1'b0;
    end else begin
      reject_reg <= 1'b0;
      if (param_wr_i) begin
        if (!in_range(param_wdata_i)) begin
          reject_reg <= (param_addr_i == stop_ctrl_pkg::PROFILE_DECEL_ADDR) ||
                        (param_addr_i == stop_ctrl_pkg::QUICK_STOP_DECEL_ADDR);
        end else if (param_addr_i == stop_ctrl_pkg::PROFILE_DECEL_ADDR) begin
          profile_decel_ramp_reg <= param_wdata_i;
        end else if (param_addr_i == stop_ctrl_pkg::QUICK_STOP_DECEL_ADDR) begin
          quick_stop_decel_ramp_reg <= param_wdata_i;
        end
      end
    end
  end

  // Reads answer one cycle later; unknown addresses read as zero.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (param_rd_i) begin
      case (param_addr_i)
        stop_ctrl_pkg::PROFILE_DECEL_ADDR: rdata_reg <= profile_decel_ramp_reg;
        stop_ctrl_pkg::QUICK_STOP_DECEL_ADDR: rdata_reg <= quick_stop_decel_ramp_reg;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Ramp timing
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_comb begin
    ramp_target = 32'h0000_0000;
    ramp_decel = profile_decel_ramp_reg;
    case (state_reg)
      stop_ctrl_pkg::ST_RUN: ramp_target = move_speed_i;
      stop_ctrl_pkg::ST_QS_DECEL: ramp_decel = quick_stop_decel_ramp_reg;
      stop_ctrl_pkg::ST_QS_HELD: ramp_decel = quick_stop_decel_ramp_reg;
      default: ramp_target = 32'h0000_0000;
    endcase
  end

  ramp_gen u_ramp_gen (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .tick_i(tick),
    .clear_i(state_reg == stop_ctrl_pkg::ST_OVERVOLT),
    .target_i(ramp_target),
    .accel_i(accel_i),
    .decel_i(ramp_decel),
    .speed_o(speed),
    .at_target_o(at_target)
  );

  // ---------------------------------------------------------------------------
  // Stop state machine
  // ---------------------------------------------------------------------------
  assign braking = (state_reg == stop_ctrl_pkg::ST_QS_DECEL) ||
                   (state_reg == stop_ctrl_pkg::ST_HALT_DECEL);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      stop_ctrl_pkg::ST_RUN: begin
        if (qs_trigger) begin
          state_next = stop_ctrl_pkg::ST_QS_DECEL;
        end else if (halt_any) begin
          state_next = stop_ctrl_pkg::ST_HALT_DECEL;
        end
      end
      stop_ctrl_pkg::ST_QS_DECEL: begin
        if (overvolt) begin
          state_next = stop_ctrl_pkg::ST_OVERVOLT;
        end else if (speed == 32'h0000_0000) begin
          state_next = stop_ctrl_pkg::ST_QS_HELD;
        end
      end
      stop_ctrl_pkg::ST_QS_HELD: begin
        if (fault_reset_i) begin
          state_next = stop_ctrl_pkg::ST_RUN;
        end
      end
      stop_ctrl_pkg::ST_HALT_DECEL: begin
        if (overvolt) begin
          state_next = stop_ctrl_pkg::ST_OVERVOLT;
        end else if (qs_trigger) begin
          state_next = stop_ctrl_pkg::ST_QS_DECEL;
        end else if (speed == 32'h0000_0000) begin
          // A halt withdrawn while braking completes the ramp, then runs again.
          state_next = halt_any ? stop_ctrl_pkg::ST_HALT_ADJUST :
                                  stop_ctrl_pkg::ST_RUN;
        end
      end
      stop_ctrl_pkg::ST_HALT_ADJUST: begin
        state_next = stop_ctrl_pkg::ST_HALT_HOLD;
      end
      stop_ctrl_pkg::ST_HALT_HOLD: begin
        if (qs_trigger) begin
          state_next = stop_ctrl_pkg::ST_QS_DECEL;
        end else if (!halt_any) begin
          state_next = stop_ctrl_pkg::ST_RUN;
        end
      end
      stop_ctrl_pkg::ST_OVERVOLT: begin
        if (fault_reset_i) begin
          state_next = stop_ctrl_pkg::ST_RUN;
        end
      end
      default: state_next = stop_ctrl_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= stop_ctrl_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Error class is latched when a quick stop starts and kept until fault reset.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      class2_reg <= 1'b0;
    end else if (state_next == stop_ctrl_pkg::ST_QS_DECEL &&
                 state_reg != stop_ctrl_pkg::ST_QS_DECEL) begin
      class2_reg <= error_class2_i;
    end else if (state_reg == stop_ctrl_pkg::ST_RUN) begin
      class2_reg <= 1'b0;
    end
  end

  // Overvoltage flag: entering the error state wins over a fault reset.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overvolt_reg <= 1'b0;
    end else if (braking && overvolt) begin
      overvolt_reg <= 1'b1;
    end else if (fault_reset_i) begin
      overvolt_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Fast position capture
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_prev_reg <= 2'h0;
      cap_valid_reg <= 2'h0;
      cap0_reg <= '0;
      cap1_reg <= '0;
    end else begin
      cap_prev_reg <= pin_level[3:2];
      cap_valid_reg <= pin_level[3:2] & ~cap_prev_reg;
      if (pin_level[2] && !cap_prev_reg[0]) begin
        cap0_reg <= motor_pos_i;
      end
      if (pin_level[3] && !cap_prev_reg[1]) begin
        cap1_reg <= motor_pos_i;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign param_rdata_o = rdata_reg;
  assign param_reject_o = reject_reg;
  assign speed_ref_o = speed;
  assign power_stage_en_o = power_req_i && (state_reg != stop_ctrl_pkg::ST_OVERVOLT) &&
                            !(state_reg == stop_ctrl_pkg::ST_QS_HELD && class2_reg);
  assign quick_stop_active_o = (state_reg == stop_ctrl_pkg::ST_QS_DECEL) ||
                               (state_reg == stop_ctrl_pkg::ST_QS_HELD);
  assign halt_active_o = halt_any;
  assign pos_adjust_o = (state_reg == stop_ctrl_pkg::ST_HALT_ADJUST);
  assign pos_hold_o = (state_reg == stop_ctrl_pkg::ST_HALT_HOLD);
  assign overvolt_err_o = overvolt_reg;
  assign move_end_o = (state_reg == stop_ctrl_pkg::ST_RUN) && at_target;
  assign capture0_pos_o = cap0_reg;
  assign capture1_pos_o = cap1_reg;
  assign capture_valid_o = cap_valid_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  quick_stop_ramp_a: assert property (
    state_reg == stop_ctrl_pkg::ST_QS_DECEL |-> ramp_decel == quick_stop_decel_ramp_reg
  ) else $error("Quick stop not using its own ramp.");

  low_class_power_a: assert property (
    state_reg == stop_ctrl_pkg::ST_QS_HELD && !class2_reg |-> power_stage_en_o == power_req_i
  ) else $error("Power stage dropped after lower-class quick stop.");

  class2_power_off_a: assert property (
    state_reg == stop_ctrl_pkg::ST_QS_HELD && class2_reg |-> !power_stage_en_o
  ) else $error("Power stage still on after class 2 quick stop.");

  overvolt_trip_a: assert property (
    braking && overvolt |=> state_reg == stop_ctrl_pkg::ST_OVERVOLT && overvolt_err_o &&
      !power_stage_en_o
  ) else $error("Overvoltage while braking not handled.");

  quick_stop_hold_a: assert property (
    state_reg == stop_ctrl_pkg::ST_QS_HELD && !fault_reset_i |=>
      state_reg == stop_ctrl_pkg::ST_QS_HELD
  ) else $error("Quick stop left without fault reset.");

  ramp_range_a: assert property (
    param_wr_i && !in_range(param_wdata_i) |=>
      quick_stop_decel_ramp_reg == $past(quick_stop_decel_ramp_reg) && profile_decel_ramp_reg ==
      $past(profile_decel_ramp_reg)
  ) else $error("Out-of-range ramp value was stored.");

  halt_adjust_hold_a: assert property (
    state_reg == stop_ctrl_pkg::ST_HALT_ADJUST |-> pos_adjust_o ##1 pos_hold_o
  ) else $error("Halt did not adjust then hold position.");

  halt_resume_a: assert property (
    state_reg == stop_ctrl_pkg::ST_HALT_HOLD && halt_any |=> state_reg != stop_ctrl_pkg::ST_RUN
  ) else $error("Movement resumed while a halt request is pending.");

  halt_finish_decel_a: assert property (
    state_reg == stop_ctrl_pkg::ST_HALT_DECEL && !overvolt && !qs_trigger && speed != 0 |=>
      state_reg == stop_ctrl_pkg::ST_HALT_DECEL
  ) else $error("Halt deceleration abandoned before standstill.");

  capture_latch_a: assert property (
    pin_level[2] && !cap_prev_reg[0] |=> capture_valid_o[0] && capture0_pos_o == $past(motor_pos_i)
  ) else $error("Capture 0 did not latch the motor position.");

endmodule

// file: drive_stop_halt_control_tb.sv
// Self-checking bench for the stop, halt and capture control block.
`timescale 1ns/1ps
module drive_stop_halt_control_tb;
  localparam int TICKS = 4;
  localparam logic [31:0] RUN_SPD = 32'h0000_2EE0;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] p_addr;
  logic [31:0] p_wdata;
  logic p_wr;
  logic p_rd;
  logic fault_reset;
  logic [31:0] move_speed = RUN_SPD;
  logic [31:0] accel = 32'h002D_C6C0;
  logic power_req = 1'b0;
  logic qs_req = 1'b0;
  logic err_low = 1'b0;
  logic err_c2 = 1'b0;
  logic halt_sw = 1'b0;
  logic halt_pin = 1'b0;
  logic dc_ov = 1'b0;
  logic [1:0] cap_pin = 2'b00;
  logic [31:0] motor_pos = 32'h0000_0000;
  logic [31:0] param_rdata_o;
  logic param_reject_o;
  logic [31:0] speed_ref_o;
  logic power_stage_en_o;
  logic quick_stop_active_o;
  logic halt_active_o;
  logic pos_adjust_o;
  logic pos_hold_o;
  logic overvolt_err_o;
  logic move_end_o;
  logic [31:0] capture0_pos_o;
  logic [31:0] capture1_pos_o;
  logic [1:0] capture_valid_o;
  logic [31:0] shadow [2];
  logic [31:0] rv;
  logic rj;
  int i;
  int k;
  int bad_count = 0;
  int n_tests = 0;

  always #25 mclk_i = ~mclk_i;

  fieldbus_master i_fieldbus_master (
    .mclk_i(mclk_i), .param_addr_o(p_addr), .param_wdata_o(p_wdata), .param_wr_o(p_wr),
    .param_rd_o(p_rd), .param_rdata_i(param_rdata_o), .param_reject_i(param_reject_o),
    .fault_reset_o(fault_reset)
  );

  drive_stop_halt_control #(.TICK_CYCLES(TICKS), .POS_W(32)) i_drive_stop_halt_control (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .param_addr_i(p_addr), .param_wdata_i(p_wdata),
    .param_wr_i(p_wr), .param_rd_i(p_rd), .param_rdata_o(param_rdata_o),
    .param_reject_o(param_reject_o), .move_speed_i(move_speed), .accel_i(accel),
    .power_req_i(power_req), .quick_stop_req_i(qs_req), .error_low_i(err_low),
    .error_class2_i(err_c2), .fault_reset_i(fault_reset), .halt_sw_i(halt_sw),
    .halt_pin_i(halt_pin), .dc_overvolt_pin_i(dc_ov), .capture_pin_i(cap_pin),
    .motor_pos_i(motor_pos), .speed_ref_o(speed_ref_o), .power_stage_en_o(power_stage_en_o),
    .quick_stop_active_o(quick_stop_active_o), .halt_active_o(halt_active_o),
    .pos_adjust_o(pos_adjust_o), .pos_hold_o(pos_hold_o), .overvolt_err_o(overvolt_err_o),
    .move_end_o(move_end_o), .capture0_pos_o(capture0_pos_o),
    .capture1_pos_o(capture1_pos_o), .capture_valid_o(capture_valid_o)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic lim(input int n, input int m);
    if (n >= m) begin
      bad_count++;
      $display("BAD wait_limit expected %0d seen %0d", m - 1, n);
      end_of_test();
    end
  endtask

  // Writes a ramp and reads it back; out-of-range values must be refused.
  task automatic acc(input logic [15:0] a, input logic [31:0] d);
    logic m;
    logic er;
    m = (a == stop_ctrl_pkg::PROFILE_DECEL_ADDR) || (a == stop_ctrl_pkg::QUICK_STOP_DECEL_ADDR);
    er = m && (d < stop_ctrl_pkg::RAMP_MIN || d > stop_ctrl_pkg::RAMP_MAX);
    i_fieldbus_master.xfer(a, d, 1'b1, rv, rj);
    chk("reject", {31'h0, er}, {31'h0, rj});
    if (m && !er) begin
      shadow[a[4]] = d;
    end
    i_fieldbus_master.xfer(a, 32'h0000_0000, 1'b0, rv, rj);
    chk("readback", m ? shadow[a[4]] : 32'h0000_0000, rv);
  endtask

  task automatic run_up();
    for (i = 0; i < 100 && move_end_o !== 1'b1; i++) @(negedge mclk_i);
    lim(i, 100);
    chk("run_speed", RUN_SPD, speed_ref_o);
  endtask

  task automatic leave_run();
    for (i = 0; i < 40 && speed_ref_o === RUN_SPD; i++) @(negedge mclk_i);
    lim(i, 40);
  endtask

  task automatic to_zero();
    for (i = 0; i < 300 && speed_ref_o !== 32'h0000_0000; i++) @(negedge mclk_i);
    lim(i, 300);
  endtask

  initial begin
    shadow[0] = stop_ctrl_pkg::QUICK_STOP_DECEL_RESET;
    shadow[1] = stop_ctrl_pkg::PROFILE_DECEL_RESET;
    repeat (20) @(posedge mclk_i);
    chk("power_idle", 32'h0, {31'h0, power_stage_en_o});
    resetn_i <= 1'b1;
    power_req <= 1'b1;
    @(negedge mclk_i);
    chk("power_on", 32'h1, {31'h0, power_stage_en_o});
    i_fieldbus_master.xfer(stop_ctrl_pkg::PROFILE_DECEL_ADDR, 32'h0, 1'b0, rv, rj);
    chk("profile_reset", shadow[1], rv);
    i_fieldbus_master.xfer(stop_ctrl_pkg::QUICK_STOP_DECEL_ADDR, 32'h0, 1'b0, rv, rj);
    chk("qs_reset", shadow[0], rv);
    acc(16'h0624, 32'h0000_00C7);
    acc(16'h0624, 32'h002D_C6C1);
    acc(16'h0624, 32'h002D_C6C0);
    acc(16'h0624, 32'h0000_00C8);
    acc(16'h0624, 32'h0000_1770);
    acc(16'h0620, 32'h0000_1234);
    acc(16'h0616, 32'h0000_03E8);
    // Software stop, lower-class error and class 2 error in turn.
    for (k = 0; k < 3; k++) begin
      run_up();
      @(posedge mclk_i);
      {err_c2, err_low, qs_req} <= 3'b001 << k;
      @(posedge mclk_i);
      {err_c2, err_low, qs_req} <= 3'b000;
      leave_run();
      chk("qs_step", RUN_SPD - shadow[0], speed_ref_o);
      chk("qs_active", 32'h1, {31'h0, quick_stop_active_o});
      to_zero();
      repeat (4) @(negedge mclk_i);
      chk("qs_power", {31'h0, k != 2}, {31'h0, power_stage_en_o});
      chk("qs_held", 32'h1, {31'h0, quick_stop_active_o});
      i_fieldbus_master.fault_reset();
      chk("qs_cleared", 32'h0, {31'h0, quick_stop_active_o});
    end
    run_up();
    @(posedge mclk_i);
    halt_sw <= 1'b1;
    halt_pin <= 1'b1;
    leave_run();
    chk("halt_step", RUN_SPD - shadow[1], speed_ref_o);
    chk("halt_or", 32'h1, {31'h0, halt_active_o});
    for (i = 0; i < 300 && pos_adjust_o !== 1'b1; i++) @(negedge mclk_i);
    lim(i, 300);
    chk("halt_speed", 32'h0, speed_ref_o);
    @(negedge mclk_i);
    chk("hold", 32'h1, {31'h0, pos_hold_o});
    chk("hold_power", 32'h1, {31'h0, power_stage_en_o});
    @(posedge mclk_i);
    halt_sw <= 1'b0;
    repeat (10) @(negedge mclk_i);
    chk("hold_pin_only", 32'h1, {31'h0, pos_hold_o});
    chk("halt_pin", 32'h1, {31'h0, halt_active_o});
    @(posedge mclk_i);
    halt_pin <= 1'b0;
    run_up();
    @(posedge mclk_i);
    halt_sw <= 1'b1;
    leave_run();
    @(posedge mclk_i);
    halt_sw <= 1'b0;
    to_zero();
    chk("no_hold", 32'h0, {31'h0, pos_hold_o});
    run_up();
    @(posedge mclk_i);
    halt_sw <= 1'b1;
    leave_run();
    @(posedge mclk_i);
    dc_ov <= 1'b1;
    for (i = 0; i < 20 && overvolt_err_o !== 1'b1; i++) @(negedge mclk_i);
    lim(i, 20);
    chk("ov_power", 32'h0, {31'h0, power_stage_en_o});
    @(posedge mclk_i);
    dc_ov <= 1'b0;
    halt_sw <= 1'b0;
    repeat (8) @(negedge mclk_i);
    chk("ov_speed", 32'h0, speed_ref_o);
    chk("ov_kept", 32'h1, {31'h0, overvolt_err_o});
    i_fieldbus_master.fault_reset();
    chk("ov_cleared", 32'h0, {31'h0, overvolt_err_o});
    @(posedge mclk_i);
    motor_pos <= 32'h1234_ABCD;
    cap_pin <= 2'b01;
    for (i = 0; i < 10 && capture_valid_o[0] !== 1'b1; i++) @(negedge mclk_i);
    lim(i, 10);
    chk("cap0", 32'h1234_ABCD, capture0_pos_o);
    @(posedge mclk_i);
    motor_pos <= 32'h0F0F_5A5A;
    cap_pin <= 2'b11;
    for (i = 0; i < 10 && capture_valid_o[1] !== 1'b1; i++) @(negedge mclk_i);
    lim(i, 10);
    chk("cap1", 32'h0F0F_5A5A, capture1_pos_o);
    chk("cap0_kept", 32'h1234_ABCD, capture0_pos_o);
    end_of_test();
  end
endmodule

// file: fieldbus_master.sv
// Fieldbus master model that sets drive parameters and issues fault resets.
`timescale 1ns/1ps
module fieldbus_master (
  // Clock
  input wire logic mclk_i,
  // Parameter port
  output logic [15:0] param_addr_o,
  output logic [31:0] param_wdata_o,
  output logic param_wr_o,
  output logic param_rd_o,
  input wire logic [31:0] param_rdata_i,
  input wire logic param_reject_i,
  // Fault reset
  output logic fault_reset_o
);
  initial begin
    param_addr_o = 16'h0000;
    param_wdata_o = 32'h0000_0000;
    param_wr_o = 1'b0;
    param_rd_o = 1'b0;
    fault_reset_o = 1'b0;
  end

  // One-cycle strobe; address and data are scrambled once released.
  task automatic xfer(input logic [15:0] a, input logic [31:0] d, input logic w,
                      output logic [31:0] rd, output logic rej);
    @(posedge mclk_i);
    param_addr_o <= a;
    param_wdata_o <= d;
    param_wr_o <= w;
    param_rd_o <= !w;
    @(posedge mclk_i);
    param_wr_o <= 1'b0;
    param_rd_o <= 1'b0;
    param_addr_o <= ~a;
    param_wdata_o <= ~d;
    @(negedge mclk_i);
    rd = param_rdata_i;
    rej = param_reject_i;
  endtask

  // A held stop is only left after this one-cycle fault reset.
  task automatic fault_reset();
    @(posedge mclk_i);
    fault_reset_o <= 1'b1;
    @(posedge mclk_i);
    fault_reset_o <= 1'b0;
    @(negedge mclk_i);
  endtask
endmodule

// file: pin_filter.sv
// Three-stage input synchroniser that accepts a level once two stages agree.
`timescale 1ns/1ps
module pin_filter #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit only changes once the second and third stages show the same value.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_reg <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_reg[i] <= stage3_reg[i];
        end
      end
    end
  end

  assign level_o = level_reg;

endmodule

// file: ramp_gen.sv
// Linear speed ramp: steps the speed reference toward its target once per tick.
`timescale 1ns/1ps
module ramp_gen (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Ramp control
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [31:0] target_i,
  input wire logic [31:0] accel_i,
  input wire logic [31:0] decel_i,
  // Ramp state
  output logic [31:0] speed_o,
  output logic at_target_o
);

  logic [31:0] speed_reg;
  logic [31:0] speed_next;
  logic [32:0] up_sum;

  // Speed is in thousandths of min^-1, so a ramp in min^-1/s is the step per ms.
  always_comb begin
    up_sum = {1'b0, speed_reg} + {1'b0, accel_i};
    speed_next = speed_reg;
    if (speed_reg < target_i) begin
      speed_next = (up_sum > {1'b0, target_i}) ? target_i : up_sum[31:0];
    end else if (speed_reg > target_i) begin
      speed_next = (speed_reg - target_i < decel_i) ? target_i : speed_reg - decel_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      speed_reg <= 32'h0000_0000;
    end else if (clear_i) begin
      speed_reg <= 32'h0000_0000;
    end else if (tick_i) begin
      speed_reg <= speed_next;
    end
  end

  assign speed_o = speed_reg;
  assign at_target_o = (speed_reg == target_i);

endmodule

// file: stop_ctrl_pkg.sv
// Shared constants and state encoding for the stop and halt control block.
package stop_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Parameter addresses and values
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] PROFILE_DECEL_ADDR = 16'h0616;
  localparam logic [15:0] QUICK_STOP_DECEL_ADDR = 16'h0624;
  localparam logic [31:0] PROFILE_DECEL_RESET = 32'h0000_02EE;
  localparam logic [31:0] QUICK_STOP_DECEL_RESET = 32'h0000_1770;
  localparam logic [31:0] RAMP_MIN = 32'h0000_00C8;
  localparam logic [31:0] RAMP_MAX = 32'h002D_C6C0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYCLES = (CLK_HZ / 1000000) * RAMP_TICK_US;
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------------------
  // Control states
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_RUN = 7'b0000001,
    ST_QS_DECEL = 7'b0000010,
    ST_QS_HELD = 7'b0000100,
    ST_HALT_DECEL = 7'b0001000,
    ST_HALT_ADJUST = 7'b0010000,
    ST_HALT_HOLD = 7'b0100000,
    ST_OVERVOLT = 7'b1000000
  } stop_state_t;

endpackage
